// ### logic/gfx_cfg_pkg.sv
// package for the configuration space, control aperture and memory window of the graphics bridge
// assumes a synchronous single-clock host-side target that decodes already-qualified bus cycles
package gfx_cfg_pkg;
  // configuration space byte offsets
  localparam logic [7:0] CFG_IDENT      = 8'h00;
  localparam logic [7:0] CFG_STATUS_CMD = 8'h04;
  localparam logic [7:0] CFG_CLASS_REV  = 8'h08;
  localparam logic [7:0] CFG_HDR_LAT    = 8'h0C;
  localparam logic [7:0] CFG_GMEM_BASE  = 8'h10;
  localparam logic [7:0] CFG_CTRL_BASE  = 8'h14;
  localparam logic [7:0] CFG_SUBSYS     = 8'h2C;
  localparam logic [7:0] CFG_ROM_BASE   = 8'h30;
  localparam logic [7:0] CFG_LAT_IRQ    = 8'h3C;
  localparam logic [7:0] CFG_CORE_CLK   = 8'h40;
  localparam logic [7:0] CFG_MEM_SETUP  = 8'h44;
  localparam logic [7:0] CFG_VID_CLK    = 8'h48;
  localparam logic [7:0] CFG_IND_INDEX  = 8'h4C;
  localparam logic [7:0] CFG_IND_VALUE  = 8'h50;
  // system control register indices
  localparam logic [8:0] SC_CMD_PTR   = 9'h02A;
  localparam logic [8:0] SC_RUN_STATE = 9'h02B;
  localparam logic [8:0] SC_LOCAL_PTR = 9'h02C;
  localparam logic [8:0] SC_HOST_PTR  = 9'h02D;
  localparam logic [8:0] SC_FLAGS     = 9'h030;
  localparam logic [8:0] SC_LINE_CMP  = 9'h031;
  localparam logic [8:0] SC_DEBUG     = 9'h032;
  localparam logic [8:0] SC_IO_CTRL   = 9'h033;
  localparam logic [8:0] SC_GPIO      = 9'h034;
  localparam logic [8:0] SC_WIN0      = 9'h036;
  localparam logic [8:0] SC_WIN1      = 9'h037;
  // synthesizer fields
  localparam int SYN_R_HI = 15;
  localparam int SYN_R_LO = 14;
  localparam int SYN_M_HI = 13;
  localparam int SYN_M_LO = 7;
  localparam int SYN_N_HI = 6;
  localparam int SYN_N_LO = 0;
  localparam int NONOVL_BIT = 31;
  // memory setup fields
  localparam int MEM_REFR_HI = 22;
  localparam int MEM_REFR_LO = 20;
  localparam int MEM_DEPTH_HI = 19;
  localparam int MEM_DEPTH_LO = 18;
  localparam int MEM_BUS_BIT = 17;
  localparam int MEM_CHIP_BIT = 16;
  // window setup fields
  localparam int WIN_LINEAR_BIT = 31;
  localparam int WIN_32BPP_BIT = 30;
  localparam int WIN_WIDTH_HI = 26;
  localparam int WIN_WIDTH_LO = 24;
  localparam int WIN_HEIGHT_HI = 21;
  localparam int WIN_HEIGHT_LO = 16;
  localparam int WIN_START_HI = 13;
  localparam int WIN_START_LO = 0;
  localparam int WIN_START_SHIFT = 11;
  localparam logic [2:0] WIN_WIDTH_RSVD = 3'h7;
  localparam int WIN_X_BASE_BITS = 5;
  // flag bits
  localparam int FLG_MASTER_IRQ = 15;
  localparam int FLG_PIX_VIS = 14;
  localparam int FLG_VID_IRQ = 13;
  // reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  // aperture unit select
  typedef enum logic [2:0] {U_PIXEL, U_VIDEO, U_SYSCTL, U_PRIM, U_CODE, U_PALETTE, U_NONE} unit_t;
  // control aperture range decode
  function automatic unit_t decode_unit(input logic [8:0] idx);
    if (idx <= 9'h010) decode_unit = U_PIXEL;
    else if (idx >= 9'h021 && idx <= 9'h028) decode_unit = U_VIDEO;
    else if (idx >= 9'h02A && idx <= 9'h037) decode_unit = U_SYSCTL;
    else if (idx >= 9'h040 && idx <= 9'h074) decode_unit = U_PRIM;
    else if (idx >= 9'h080 && idx <= 9'h09F) decode_unit = U_CODE;
    else if (idx >= 9'h100) decode_unit = U_PALETTE;
    else decode_unit = U_NONE;
  endfunction : decode_unit
endpackage : gfx_cfg_pkg

// ### logic/clk_synth_ratio.sv
// clock synthesizer setting: splits an R/M/N word into divider controls
// assumes the analog synthesizer consumes the fields as levels
`timescale 1ns/100ps
module clk_synth_ratio
  import gfx_cfg_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [31:0] cfg_word,
  output logic [1:0]       r_exp,
  output logic [6:0]       m_fac,
  output logic [6:0]       n_div,
  output logic             long_nonovl
);
  // fields registered so the synthesizer never sees a half-written word
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      r_exp       <= 2'h0;
      m_fac       <= 7'h00;
      n_div       <= 7'h00;
      long_nonovl <= 1'b0;
    end else begin
      r_exp       <= cfg_word[SYN_R_HI:SYN_R_LO];
      m_fac       <= cfg_word[SYN_M_HI:SYN_M_LO];
      n_div       <= cfg_word[SYN_N_HI:SYN_N_LO];
      long_nonovl <= cfg_word[NONOVL_BIT];
    end
  end
endmodule : clk_synth_ratio

// ### logic/window_xlate.sv
// one memory aperture: raw or linear frame buffer address translation
// assumes window offset is already stripped of the base and the aperture select bit
`timescale 1ns/100ps
module window_xlate
  import gfx_cfg_pkg::*;
#(
  parameter int ADDR_W = 24
) (
  input  wire logic [31:0]       setup,
  input  wire logic [ADDR_W-1:0] offs,
  output logic [ADDR_W+2:0]      phys,
  output logic                   wide_pix
);
  initial begin
    if (ADDR_W < 16) $error("window too small");
  end
  logic [2:0]         wcode;   // width code
  logic [5:0]         height;  // height field
  logic [13:0]        start;   // start field
  logic [ADDR_W+2:0]  raw_a;   // raw translation
  logic [ADDR_W+2:0]  lin_a;   // linear translation
  logic [ADDR_W+2:0]  xpart;   // x coordinate bits
  logic [ADDR_W+2:0]  ypart;   // y coordinate bits
  int                 xbits;   // x width in bits
  always_comb begin
    wcode  = setup[WIN_WIDTH_HI:WIN_WIDTH_LO];
    height = setup[WIN_HEIGHT_HI:WIN_HEIGHT_LO];
    start  = setup[WIN_START_HI:WIN_START_LO];
    xbits  = WIN_X_BASE_BITS + ((wcode == WIN_WIDTH_RSVD) ? 6 : int'(wcode));
    raw_a  = (ADDR_W+3)'(offs) + ((ADDR_W+3)'(start) << WIN_START_SHIFT);
    xpart  = (ADDR_W+3)'(offs) & (((ADDR_W+3)'(1) << xbits) - (ADDR_W+3)'(1));
    ypart  = (ADDR_W+3)'(offs) >> xbits;
    // y offset by height, placed at start
    lin_a  = raw_a - (ADDR_W+3)'(offs) + xpart + (((ypart + (ADDR_W+3)'(height)) << xbits));
    phys     = setup[WIN_LINEAR_BIT] ? lin_a : raw_a;
    wide_pix = setup[WIN_LINEAR_BIT] & setup[WIN_32BPP_BIT];
  end
endmodule : window_xlate

// ### logic/pci_config_aperture_decode.sv
// host-side target: configuration words, indirect access, control aperture and memory window
// assumes the bus front end hands over qualified cycles with byte enables, one cycle each
// Behaviour
// - core clock from R, M, N fields
// - bit 31 of the core clock word selects clock non-overlap length
// - video clock word at 72, same fields
// - memory setup refresh, depth, width, chips
// - indirect write fires on top byte write
// - control register k at base plus 4k
// - index ranges routed to internal units
// - 32 Mbyte window, top bit picks aperture
// - raw mode adds start times 2048
// - linear mode splits x and y
// - x, y combined with start, height
// - two apertures configured independently
// - master fetch pointer and run enable; local and host pointers stored and read back only
// - gpio pins follow extra io register
// - bit 31 linear, bit 30 wide pixels when linear
// - width code gives x bits, 7 reserved
// - sticky flags clear on write one
`timescale 1ns/100ps
module pci_config_aperture_decode
  import gfx_cfg_pkg::*;
#(
  parameter logic [31:0] IDENT_VAL  = 32'h0001_0001,  // arbitrary value
  parameter logic [31:0] CLASS_VAL  = 32'h0300_0001,  // arbitrary value
  parameter logic [31:0] SUBSYS_VAL = 32'h0001_0001,  // arbitrary value
  parameter int          GPIO_W     = 5
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // configuration cycles
  input  wire logic              cfg_wr,
  input  wire logic              cfg_rd,
  input  wire logic [7:0]        cfg_addr,
  input  wire logic [3:0]        cfg_be,
  input  wire logic [31:0]       cfg_wdata,
  output logic [31:0]            cfg_rdata,
  output logic                   cfg_rvalid,
  // memory cycles
  input  wire logic              mem_wr,
  input  wire logic              mem_rd,
  input  wire logic [31:0]       mem_addr,
  input  wire logic [31:0]       mem_wdata,
  output logic [31:0]            mem_rdata,
  output logic                   mem_rvalid,
  // internal register port
  output logic                   reg_wr,
  output logic [8:0]             reg_index,
  output logic [31:0]            reg_wdata,
  output logic [2:0]             reg_unit,
  // graphics memory port
  output logic                   gmem_req,
  output logic                   gmem_we,
  output logic [26:0]            gmem_addr,
  output logic [31:0]            gmem_wdata,
  output logic                   gmem_wide,
  // clocks and memory setup
  output logic [1:0]             core_r,
  output logic [6:0]             core_m,
  output logic [6:0]             core_n,
  output logic                   core_nonovl,
  output logic [1:0]             vid_r,
  output logic [6:0]             vid_m,
  output logic [6:0]             vid_n,
  output logic [2:0]             mem_refresh,
  output logic [1:0]             mem_bank_depth,
  output logic                   mem_bus_width_sel,
  output logic                   mem_chip_width_sel,
  // master control
  output logic [31:0]            master_cmd_addr,
  output logic                   master_run,
  input  wire logic [23:0]       master_count,
  // event sources
  input  wire logic              master_irq_evt,
  input  wire logic              pix_vis_evt,
  input  wire logic              vid_irq_evt,
  input  wire logic [4:0]        unit_state,
  input  wire logic [10:0]       video_y,
  // general purpose pins
  input  wire logic [GPIO_W-1:0] gpio_in,
  output logic [GPIO_W-1:0]      gpio_out,
  output logic [GPIO_W-1:0]      gpio_oe,
  output logic                   flags_any
);
  initial begin
    if (GPIO_W < 1 || GPIO_W > 16) $error("gpio width unsupported");
  end

  // configuration storage
  logic [31:0] cmd_ff;        // command half
  logic [31:0] hdr_ff;        // latency and line size
  logic [31:0] gbase_ff;      // graphics window base
  logic [31:0] cbase_ff;      // control aperture base
  logic [31:0] rom_ff;        // boot rom base
  logic [31:0] irq_ff;        // interrupt line
  logic [31:0] core_ff;       // core clock word
  logic [31:0] memcfg_ff;     // memory setup word
  logic [31:0] vid_ff;        // video clock word
  logic [31:0] idx_ff;        // indirect index
  logic [31:0] ival_ff;       // indirect data staging
  // system control storage
  logic [31:0] cmdptr_ff;     // master command pointer
  logic [7:0]  mstate_ff;     // master run state
  logic [31:0] lptr_ff;       // master local pointer
  logic [31:0] hptr_ff;       // master host pointer
  logic [2:0]  flags_ff;      // sticky flags
  logic [11:0] lcmp_ff;       // line compare
  logic [31:0] dbg_ff;        // debug word
  logic [31:0] ioc_ff;        // io control
  logic [31:0] gpio_ff;       // extra io word
  logic [31:0] win0_ff;       // aperture 0 setup
  logic [31:0] win1_ff;       // aperture 1 setup

  // byte-lane merge for configuration writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      if (be[i]) old[i*8 +: 8] = nw[i*8 +: 8];
    end
    merge = old;
  endfunction : merge

  // stored word at the addressed offset, so one merger serves every configuration word
  logic [31:0] cfg_old;       // word before the write
  logic [31:0] cfg_mrg;       // word with enabled lanes replaced
  always_comb begin
    case (cfg_addr)
      CFG_STATUS_CMD: cfg_old = cmd_ff;
      CFG_HDR_LAT:    cfg_old = hdr_ff;
      CFG_GMEM_BASE:  cfg_old = gbase_ff;
      CFG_CTRL_BASE:  cfg_old = cbase_ff;
      CFG_ROM_BASE:   cfg_old = rom_ff;
      CFG_LAT_IRQ:    cfg_old = irq_ff;
      CFG_CORE_CLK:   cfg_old = core_ff;
      CFG_MEM_SETUP:  cfg_old = memcfg_ff;
      CFG_VID_CLK:    cfg_old = vid_ff;
      CFG_IND_INDEX:  cfg_old = idx_ff;
      CFG_IND_VALUE:  cfg_old = ival_ff;
      default:        cfg_old = RST_ZERO;
    endcase
    cfg_mrg = merge(cfg_old, cfg_wdata, cfg_be);
  end

  // control aperture decode
  logic        ctl_hit;      // address inside control aperture
  logic [8:0]  ctl_idx;      // register index
  logic        win_hit;      // address inside graphics window
  logic        ind_fire;     // indirect write completes
  logic        sc_wr;        // system control write strobe
  logic [8:0]  sc_idx;       // system control index
  logic [31:0] sc_data;      // system control data
  logic [31:0] off_ctl;      // offset within control aperture
  logic [31:0] off_win;      // offset within window
  always_comb begin
    off_ctl  = mem_addr - cbase_ff;
    off_win  = mem_addr - gbase_ff;
    // index is byte offset over four
    ctl_hit  = (off_ctl[31:11] == 21'h0);
    ctl_idx  = off_ctl[10:2];
    win_hit  = (off_win[31:25] == 7'h00);
    // top byte lane completes the write
    ind_fire = cfg_wr && cfg_addr == CFG_IND_VALUE && cfg_be[3];
    // indirect path wins, a control aperture memory write in the same cycle is dropped
    sc_wr    = ind_fire ? 1'b1 : (mem_wr && ctl_hit);
    sc_idx   = ind_fire ? idx_ff[8:0] : ctl_idx;
    sc_data  = ind_fire ? cfg_mrg : mem_wdata;
  end

  // configuration writes
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cmd_ff <= RST_ZERO; hdr_ff <= RST_ZERO; gbase_ff <= RST_ZERO; cbase_ff <= RST_ZERO;
      rom_ff <= RST_ZERO; irq_ff <= RST_ZERO; core_ff <= RST_ZERO; memcfg_ff <= RST_ZERO;
      vid_ff <= RST_ZERO; idx_ff <= RST_ZERO; ival_ff <= RST_ZERO;
    end else if (cfg_wr) begin
      case (cfg_addr)
        CFG_STATUS_CMD: cmd_ff <= {16'h0000, cfg_mrg[15:0]};
        CFG_HDR_LAT:    hdr_ff <= {16'h0000, cfg_mrg[15:0]};
        CFG_GMEM_BASE:  gbase_ff <= {cfg_mrg[31:25], 25'h0};
        CFG_CTRL_BASE:  cbase_ff <= {cfg_mrg[31:11], 11'h0};
        CFG_ROM_BASE:   rom_ff <= {cfg_mrg[31:16], 16'h0};
        CFG_LAT_IRQ:    irq_ff <= {24'h0, cfg_mrg[7:0]};
        CFG_CORE_CLK:   core_ff <= cfg_mrg;
        CFG_MEM_SETUP:  memcfg_ff <= cfg_mrg;
        CFG_VID_CLK:    vid_ff <= cfg_mrg;
        CFG_IND_INDEX:  idx_ff <= cfg_mrg;
        CFG_IND_VALUE:  ival_ff <= cfg_mrg;
        default: ;
      endcase
    end
  end

  // system control writes, set beats clear for sticky flags
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cmdptr_ff <= RST_ZERO; mstate_ff <= 8'h00; lptr_ff <= RST_ZERO; hptr_ff <= RST_ZERO;
      flags_ff <= 3'h0; lcmp_ff <= 12'h000; dbg_ff <= RST_ZERO; ioc_ff <= RST_ZERO;
      gpio_ff <= RST_ZERO; win0_ff <= RST_ZERO; win1_ff <= RST_ZERO;
    end else begin
      flags_ff <= (flags_ff & ~((sc_wr && sc_idx == SC_FLAGS) ?
                  sc_data[FLG_MASTER_IRQ:FLG_VID_IRQ] : 3'h0))
                  | {master_irq_evt, pix_vis_evt, vid_irq_evt};
      if (sc_wr) begin
        case (sc_idx)
          SC_CMD_PTR:   cmdptr_ff <= sc_data;
          SC_RUN_STATE: mstate_ff <= sc_data[31:24];
          SC_LOCAL_PTR: lptr_ff <= sc_data;
          SC_HOST_PTR:  hptr_ff <= sc_data;
          SC_LINE_CMP:  lcmp_ff <= sc_data[11:0];
          SC_DEBUG:     dbg_ff <= sc_data;
          SC_IO_CTRL:   ioc_ff <= sc_data;
          SC_GPIO:      gpio_ff <= sc_data;
          SC_WIN0:      win0_ff <= sc_data;
          SC_WIN1:      win1_ff <= sc_data;
          default: ;
        endcase
      end
    end
  end

  // configuration reads, one cycle later
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_rdata  <= RST_ZERO;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg_rd;
      case (cfg_addr)
        CFG_IDENT:      cfg_rdata <= IDENT_VAL;
        CFG_STATUS_CMD: cfg_rdata <= cmd_ff;
        CFG_CLASS_REV:  cfg_rdata <= CLASS_VAL;
        CFG_HDR_LAT:    cfg_rdata <= hdr_ff;
        CFG_GMEM_BASE:  cfg_rdata <= gbase_ff;
        CFG_CTRL_BASE:  cfg_rdata <= cbase_ff;
        CFG_SUBSYS:     cfg_rdata <= SUBSYS_VAL;
        CFG_ROM_BASE:   cfg_rdata <= rom_ff;
        CFG_LAT_IRQ:    cfg_rdata <= {16'h0000, 8'h01, irq_ff[7:0]};
        CFG_CORE_CLK:   cfg_rdata <= core_ff;
        CFG_MEM_SETUP:  cfg_rdata <= memcfg_ff;
        CFG_VID_CLK:    cfg_rdata <= vid_ff;
        CFG_IND_INDEX:  cfg_rdata <= idx_ff;
        default:        cfg_rdata <= RST_ZERO;
      endcase
    end
  end

  // memory reads of the system control range
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mem_rdata  <= RST_ZERO;
      mem_rvalid <= 1'b0;
    end else begin
      mem_rvalid <= mem_rd && (ctl_hit || win_hit);
      case (ctl_idx)
        SC_CMD_PTR:   mem_rdata <= cmdptr_ff;
        SC_RUN_STATE: mem_rdata <= {mstate_ff, master_count};
        SC_LOCAL_PTR: mem_rdata <= lptr_ff;
        SC_HOST_PTR:  mem_rdata <= hptr_ff;
        SC_FLAGS:     mem_rdata <= {5'h0, video_y, flags_ff, 8'h00, unit_state};
        SC_LINE_CMP:  mem_rdata <= {20'h0, lcmp_ff};
        SC_DEBUG:     mem_rdata <= dbg_ff;
        SC_IO_CTRL:   mem_rdata <= ioc_ff;
        // pins read back until an enable is set
        SC_GPIO:      mem_rdata <= {16'h0, gpio_ff[31:16] == 16'h0 ? 16'(gpio_in) : gpio_ff[15:0]};
        SC_WIN0:      mem_rdata <= win0_ff;
        SC_WIN1:      mem_rdata <= win1_ff;
        default:      mem_rdata <= RST_ZERO;
      endcase
    end
  end

  // internal register port toward units
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_wr <= 1'b0; reg_index <= 9'h000; reg_wdata <= RST_ZERO; reg_unit <= 3'h0;
    end else begin
      reg_wr    <= sc_wr;
      reg_index <= sc_idx;
      reg_wdata <= sc_data;
      reg_unit  <= 3'(decode_unit(sc_idx));
    end
  end

  // graphics window translation, aperture chosen by bit 24
  logic [26:0] phys0, phys1;  // per-aperture addresses
  logic        wide0, wide1;  // per-aperture pixel size
  window_xlate #(.ADDR_W(24)) u_win0 (.setup(win0_ff), .offs(off_win[23:0]), .phys(phys0), .wide_pix(wide0));
  window_xlate #(.ADDR_W(24)) u_win1 (.setup(win1_ff), .offs(off_win[23:0]), .phys(phys1), .wide_pix(wide1));
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gmem_req <= 1'b0; gmem_we <= 1'b0; gmem_addr <= 27'h0; gmem_wdata <= RST_ZERO; gmem_wide <= 1'b0;
    end else begin
      gmem_req   <= (mem_wr || mem_rd) && win_hit;
      gmem_we    <= mem_wr && win_hit;
      gmem_addr  <= off_win[24] ? phys1 : phys0;
      gmem_wide  <= off_win[24] ? wide1 : wide0;
      gmem_wdata <= mem_wdata;
    end
  end

  // clock synthesizer fields
  // non-overlap select follows bit 31
  clk_synth_ratio u_core (.clk_sys(clk_sys), .rst(rst), .cfg_word(core_ff),
                          .r_exp(core_r), .m_fac(core_m), .n_div(core_n), .long_nonovl(core_nonovl));
  clk_synth_ratio u_vid (.clk_sys(clk_sys), .rst(rst), .cfg_word(vid_ff),
                         .r_exp(vid_r), .m_fac(vid_m), .n_div(vid_n), .long_nonovl());

  // memory setup, master, pins and flag summary
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mem_refresh <= 3'h0; mem_bank_depth <= 2'h0; mem_bus_width_sel <= 1'b0; mem_chip_width_sel <= 1'b0;
      master_cmd_addr <= RST_ZERO; master_run <= 1'b0; flags_any <= 1'b0;
      gpio_out <= '0; gpio_oe <= '0;
    end else begin
      mem_refresh        <= memcfg_ff[MEM_REFR_HI:MEM_REFR_LO];
      mem_bank_depth     <= memcfg_ff[MEM_DEPTH_HI:MEM_DEPTH_LO];
      mem_bus_width_sel  <= memcfg_ff[MEM_BUS_BIT];
      mem_chip_width_sel <= memcfg_ff[MEM_CHIP_BIT];
      master_cmd_addr    <= cmdptr_ff;
      // master runs on nonzero state with bus master enable
      master_run         <= (mstate_ff != 8'h00) && cmd_ff[2];
      flags_any          <= |flags_ff;
      // low half data, high half enables
      gpio_out           <= gpio_ff[GPIO_W-1:0];
      gpio_oe            <= gpio_ff[16 +: GPIO_W];
    end
  end
endmodule : pci_config_aperture_decode

// ### tb/pci_cfg_sva.sv
// checker: field and cycle relations seen at the bridge's top ports
// assumes it is bound onto every pci_config_aperture_decode instance
`timescale 1ns/100ps
module pci_cfg_sva (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        cfg_wr,
  input wire logic        cfg_rd,
  input wire logic        mem_wr,
  input wire logic        reg_wr,
  input wire logic        cfg_rvalid,
  input wire logic        core_nonovl,
  input wire logic        flags_any,
  input wire logic        master_irq_evt,
  input wire logic        gmem_req,
  input wire logic        gmem_wide,
  input wire logic [7:0]  cfg_addr,
  input wire logic [3:0]  cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic [6:0]  core_m,
  input wire logic [1:0]  core_r,
  input wire logic [6:0]  vid_n,
  input wire logic [2:0]  reg_unit,
  input wire logic [4:0]  gpio_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // write into the indirect value word
  wire ind = cfg_wr && cfg_addr == 8'h50;
  wire wk  = cfg_wr && cfg_be == 4'hF;
  a_ind_fire: assert property (ind && cfg_be[3] |=> reg_wr) else $error("indirect fire lost");
  a_ind_hold: assert property (ind && !cfg_be[3] && !mem_wr |=> !reg_wr) else $error("early fire");
  a_core_word: assert property (wk && cfg_addr == 8'h40 |-> ##2 core_m == $past(cfg_wdata[13:7], 2)
    && core_r == $past(cfg_wdata[15:14], 2)) else $error("core fields wrong");
  a_nonovl_bit: assert property (wk && cfg_addr == 8'h40 |-> ##2 core_nonovl == $past(cfg_wdata[31], 2))
    else $error("nonoverlap wrong");
  a_vid_word: assert property (wk && cfg_addr == 8'h48 |-> ##2 vid_n == $past(cfg_wdata[6:0], 2))
    else $error("video fields wrong");
  a_rsvd_zero: assert property (cfg_rd && cfg_addr == 8'h18 |=> cfg_rvalid && cfg_rdata == 32'h0)
    else $error("reserved not zero");
  a_flag_set: assert property (master_irq_evt |-> ##[1:2] flags_any) else $error("flag not set");
  a_reg_cause: assert property (reg_wr |-> $past(mem_wr || cfg_wr)) else $error("stray reg write");
  a_gpio_cause: assert property ($changed(gpio_oe) |-> $past(mem_wr || cfg_wr) || $past(mem_wr || cfg_wr, 2))
    else $error("stray pin change");
  c_palette: cover property (reg_wr && reg_unit == 3'h5);
  c_wide: cover property (gmem_req && gmem_wide);
  c_read: cover property (cfg_rvalid);
endmodule : pci_cfg_sva
bind pci_config_aperture_decode pci_cfg_sva chk (.clk_sys, .rst, .cfg_wr, .cfg_rd, .mem_wr, .reg_wr,
  .cfg_rvalid, .core_nonovl, .flags_any, .master_irq_evt, .gmem_req, .gmem_wide, .cfg_addr, .cfg_be,
  .cfg_wdata, .cfg_rdata, .core_m, .core_r, .vid_n, .reg_unit, .gpio_oe);

// ### tb/host_bus_model.sv
// host side: issues one-cycle config and memory cycles like host software would
// assumes requests are taken on the rising edge after they are raised
`timescale 1ns/100ps
module host_bus_model (
  input wire logic clk_sys,
  output logic cfg_wr, cfg_rd, mem_wr, mem_rd,
  output logic [7:0] cfg_addr,
  output logic [3:0] cfg_be,
  output logic [31:0] cfg_wdata, mem_addr, mem_wdata
);
  initial {cfg_wr, cfg_rd, mem_wr, mem_rd, cfg_addr, cfg_be, cfg_wdata, mem_addr, mem_wdata} = '0;
  // config cycle; write data released to a changing pattern afterwards, address held
  task cyc(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge clk_sys);
    {cfg_wr, cfg_rd} <= {w, !w};
    cfg_addr <= a;
    cfg_be <= b;
    cfg_wdata <= d;
    @(posedge clk_sys);
    {cfg_wr, cfg_rd} <= 2'h0;
    cfg_wdata <= ~d;
  endtask : cyc
  // memory cycle of one word
  task mcyc(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {mem_wr, mem_rd} <= {w, !w};
    mem_addr <= a;
    mem_wdata <= d;
    @(posedge clk_sys);
    {mem_wr, mem_rd} <= 2'h0;
    mem_wdata <= ~d;
  endtask : mcyc
  task ind(input logic [8:0] i, input logic [3:0] b, input logic [31:0] d);
    cyc(1'b1, 8'h4C, 4'hF, {23'h0, i});
    cyc(1'b1, 8'h50, b, d);
  endtask : ind
endmodule : host_bus_model

// ### tb/pci_config_aperture_decode_tb_top.sv
// bench: directed config, indirect, aperture, window, flag and pin sequences
// assumes host_bus_model drives the host cycles
`timescale 1ns/100ps
module pci_config_aperture_decode_tb_top;
  import gfx_cfg_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, irq = 1'b0, pix = 1'b0, vid = 1'b0;
  logic cfg_wr, cfg_rd, mem_wr, mem_rd, cfg_rvalid, mem_rvalid, reg_wr, gmem_req, gmem_wide, gmem_we, master_run;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, mem_addr, mem_wdata, cfg_rdata, mem_rdata, reg_wdata, gmem_wdata, master_cmd_addr;
  logic [8:0] reg_index;
  logic [2:0] reg_unit, mem_refresh;
  logic [26:0] gmem_addr;
  logic [6:0] core_m, core_n, vid_m, vid_n;
  logic [1:0] core_r, vid_r, mem_bank_depth;
  logic core_nonovl, mem_bus_width_sel, mem_chip_width_sel, flags_any;
  logic [4:0] gpio_out, gpio_oe;
  int n_mismatch = 0, total_checks = 0, cyc_n = 0;
  initial forever #25 clk_sys = ~clk_sys;
  host_bus_model h (.clk_sys, .cfg_wr, .cfg_rd, .mem_wr, .mem_rd, .cfg_addr, .cfg_be, .cfg_wdata,
    .mem_addr, .mem_wdata);
  pci_config_aperture_decode dut (.clk_sys, .rst, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata,
    .cfg_rdata, .cfg_rvalid, .mem_wr, .mem_rd, .mem_addr, .mem_wdata, .mem_rdata, .mem_rvalid, .reg_wr,
    .reg_index, .reg_wdata, .reg_unit, .gmem_req, .gmem_we, .gmem_addr, .gmem_wdata, .gmem_wide,
    .core_r, .core_m, .core_n, .core_nonovl, .vid_r, .vid_m, .vid_n, .mem_refresh, .mem_bank_depth,
    .mem_bus_width_sel, .mem_chip_width_sel, .master_cmd_addr, .master_run, .master_count(24'h0),
    .master_irq_evt(irq), .pix_vis_evt(pix), .vid_irq_evt(vid), .unit_state(5'h0), .video_y(11'h003),
    .gpio_in(5'h0A), .gpio_out, .gpio_oe, .flags_any);
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  // cut a hang short
  always @(posedge clk_sys) if (++cyc_n == 4000) begin
    n_mismatch++;
    final_report;
  end
  task mw(input logic [8:0] i, input logic [31:0] d); h.mcyc(1'b1, 32'h0001_0000 + 4 * i, d); endtask : mw
  task mr(input logic [8:0] i, input logic [31:0] e);
    h.mcyc(1'b0, 32'h0001_0000 + 4 * i, 32'h0);
    #1 chk("rvalid", mem_rvalid, 1);
    chk("rdata", mem_rdata, e);
  endtask : mr
  logic [8:0] idx [7] = '{9'h000, 9'h021, 9'h02A, 9'h040, 9'h080, 9'h100, 9'h029};
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    h.cyc(1'b1, 8'h18, 4'hF, 32'hFFFF_FFFF);
    h.cyc(1'b0, 8'h18, 4'hF, 32'h0);
    #1 chk("rsvd", cfg_rdata, 0);
    h.cyc(1'b1, 8'h40, 4'hF, 32'h8000_9A85);
    h.cyc(1'b1, 8'h48, 4'hF, 32'h0000_4103);
    h.cyc(1'b1, 8'h44, 4'hF, 32'h0057_0000);
    @(posedge clk_sys) #1 chk("core", {core_nonovl, core_r, core_m, core_n}, {1'b1, 2'h2, 7'h35, 7'h05});
    chk("vid", {vid_r, vid_m, vid_n}, {2'h1, 7'h02, 7'h03});
    chk("mem", {mem_refresh, mem_bank_depth, mem_bus_width_sel, mem_chip_width_sel}, 7'h57);
    h.cyc(1'b0, 8'h40, 4'hF, 32'h0);
    #1 chk("cfgrd", cfg_rdata, 32'h8000_9A85);
    h.ind(9'h030, 4'h1, 32'h0000_00AA);
    #1 chk("partial", reg_wr, 0);
    h.cyc(1'b1, 8'h50, 4'h8, 32'h1200_0000);
    #1 chk("fire", {reg_wr, reg_index, reg_unit}, {1'b1, 9'h030, 3'h2});
    chk("fdata", reg_wdata, 32'h1200_00AA);
    h.cyc(1'b1, 8'h14, 4'hF, 32'h0001_0000);
    h.cyc(1'b1, 8'h10, 4'hF, 32'h0200_0000);
    for (int u = 0; u < 7; u++) begin
      mw(idx[u], 32'h0);
      #1 chk("unit", {reg_wr, reg_index, reg_unit}, {1'b1, idx[u], 3'(u)});
    end
    mw(SC_WIN0, 32'h0000_0003);
    mw(SC_WIN1, 32'hC102_0000);
    h.mcyc(1'b1, 32'h0200_0100, 32'h5);
    #1 chk("raw", {gmem_req, gmem_we, gmem_wide, gmem_addr}, {3'h6, 27'h1900});
    chk("wdat", gmem_wdata, 32'h5);
    h.mcyc(1'b1, 32'h0300_00C5, 32'h5);
    #1 chk("lin", {gmem_req, gmem_we, gmem_wide, gmem_addr}, {3'h7, 27'h145});
    h.mcyc(1'b1, 32'h0200_0100, 32'h5);
    #1 chk("both", gmem_addr, 32'h1900);
    @(posedge clk_sys) {irq, pix, vid} <= 3'h7;
    @(posedge clk_sys) {irq, pix, vid} <= 3'h0;
    mr(SC_FLAGS, 32'h0003_E000);
    mw(SC_FLAGS, 32'h0000_E000);
    mr(SC_FLAGS, 32'h0003_0000);
    mr(SC_GPIO, 32'h0000_000A);
    mw(SC_GPIO, 32'h0003_0015);
    repeat (2) @(posedge clk_sys);
    #1 chk("gpio", {gpio_oe, gpio_out}, {5'h03, 5'h15});
    mr(SC_GPIO, 32'h0000_0015);
    h.cyc(1'b1, 8'h04, 4'hF, 32'h0000_0004);
    mw(SC_CMD_PTR, 32'h0000_1230);
    mw(SC_RUN_STATE, 32'h0100_0000);
    @(posedge clk_sys) #1 chk("run", master_run, 1);
    chk("cmdp", master_cmd_addr, 32'h0000_1230);
    final_report;
  end
endmodule : pci_config_aperture_decode_tb_top
